// file: hw/sev_status_event.sv
// Status and event reporting unit: latch, masks, summary byte, queues.
`timescale 1ns/1ps

// Functional notes
// - Five 8-bit registers, output and event queues.
// - Enabled events set their latch bit.
// - Latch bits: POWER_ON_FLAG,USER_REQUEST_FLAG,COMMAND_PARSE_ERROR,EXECUTION_ERROR,DDE,QUERY_ERROR,CONTROL_REQUEST_FLAG,OPERATION_COMPLETE.
// - Latch read returns value then clears.
// - Empty read or lost response sets QUERY_ERROR.
// - OPERATION_COMPLETE set when pending operations finish.
// - Bit 6 is SERVICE_REQUESTED_FLAG on poll, summary on query.
// - Querying status byte changes nothing.
// - Bit 5 is masked latch summary.
// - Bit 4 shows response available.
// - Record enable gates latch and queue.
// - Summary mask selects bits feeding bit 5.
// - Service mask bits 5,4 drive summary, request.
// - SERVICE_REQUESTED_FLAG holds until poll or summary drops.
// - Power-on-clear loads 255, 0, 0.
// - Without power-on-clear masks survive power cycle.
// - New message after terminator empties output queue.
// - Second query drops first response, flags QUERY_ERROR.
// - Forty entries; overflow overwrites last with 350.
// - Queue reads remove entries; three read forms.
// - Latch read discards unfetched summarized events.
// - Later events hidden until next latch read.
module sev_status_event #(
  parameter logic [15:0] PON_CODE = 16'h0001,
  parameter logic [15:0] QYE_CODE = 16'h0002,
  parameter logic [15:0] OPC_CODE = 16'h0003
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ev_valid,
  input  wire logic [2:0]  ev_bit,
  input  wire logic [15:0] ev_code,
  input  wire logic        opc_cmd,
  input  wire logic        ops_pending,
  input  wire logic        oq_put,
  input  wire logic        oq_take,
  input  wire logic        oq_read,
  input  wire logic        oq_read_pending,
  input  wire logic        msg_start,
  input  wire logic        cmd_valid,
  input  wire logic [3:0]  cmd_op,
  input  wire logic [7:0]  cmd_data,
  output logic             cmd_ready,
  output logic [7:0]       resp_data,
  output logic             resp_valid,
  output logic [15:0]      evq_code,
  output logic             evq_valid,
  output logic             evq_text,
  output logic             evq_last,
  output logic             service_request,
  input  wire logic        nv_psc_in,
  input  wire logic [7:0]  nv_ere_in,
  input  wire logic [7:0]  nv_sem_in,
  input  wire logic [7:0]  nv_srm_in,
  output logic             nv_psc_out,
  output logic [7:0]       nv_ere_out,
  output logic [7:0]       nv_sem_out,
  output logic [7:0]       nv_srm_out
);

  // ***********************************************************
  // Queue index arithmetic
  // ***********************************************************
  function automatic logic [5:0] sev_wrap(input logic [5:0] a,
                                          input logic [5:0] b);
    logic [6:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, sev_pkg::SEV_EVQ_DEPTH})
    begin
      s = s - {1'b0, sev_pkg::SEV_EVQ_DEPTH};
    end
    return s[5:0];
  endfunction

  // ***********************************************************
  // State
  // ***********************************************************
  logic [7:0]        latch_reg;
  logic [7:0]        latch_next;
  logic [7:0]        ere_reg;
  logic [7:0]        ere_next;
  logic [7:0]        sem_reg;
  logic [7:0]        sem_next;
  logic [7:0]        srm_reg;
  logic [7:0]        srm_next;
  logic              psc_reg;
  logic              psc_next;
  logic              rqs_reg;
  logic              rqs_next;
  logic              sum_d_reg;
  logic              oq_full_reg;
  logic              oq_full_next;
  logic              opc_armed_reg;
  logic              opc_armed_next;
  logic              pon_pulse_reg;
  logic [2:0]        pend_reg;
  logic [2:0]        pend_next;
  logic [5:0]        rd_reg;
  logic [5:0]        rd_next;
  logic [5:0]        wr_reg;
  logic [5:0]        wr_next;
  logic [5:0]        count_reg;
  logic [5:0]        count_next;
  logic [5:0]        avail_reg;
  logic [5:0]        avail_next;
  logic [15:0]       evq_mem [0:39];
  sev_pkg::sev_rd_e  rd_state_reg;
  sev_pkg::sev_rd_e  rd_state_next;
  logic [7:0]        resp_next;
  logic              resp_valid_next;

  // ***********************************************************
  // Command decode
  // ***********************************************************
  wire       cmd_go    = cmd_valid & cmd_ready;
  wire       do_latch  = cmd_go & (cmd_op == sev_pkg::SEV_CMD_LATCH_RD);
  wire       do_stb    = cmd_go & (cmd_op == sev_pkg::SEV_CMD_STB_QRY);
  wire       do_poll   = cmd_go & (cmd_op == sev_pkg::SEV_CMD_POLL);
  wire       do_ere_wr = cmd_go & (cmd_op == sev_pkg::SEV_CMD_ERE_WR);
  wire       do_ere_rd = cmd_go & (cmd_op == sev_pkg::SEV_CMD_ERE_RD);
  wire       do_sem_wr = cmd_go & (cmd_op == sev_pkg::SEV_CMD_SEM_WR);
  wire       do_sem_rd = cmd_go & (cmd_op == sev_pkg::SEV_CMD_SEM_RD);
  wire       do_srm_wr = cmd_go & (cmd_op == sev_pkg::SEV_CMD_SRM_WR);
  wire       do_srm_rd = cmd_go & (cmd_op == sev_pkg::SEV_CMD_SRM_RD);
  wire       do_psc_wr = cmd_go & (cmd_op == sev_pkg::SEV_CMD_PSC_WR);
  wire       do_psc_rd = cmd_go & (cmd_op == sev_pkg::SEV_CMD_PSC_RD);
  wire       do_code   = cmd_go & (cmd_op == sev_pkg::SEV_CMD_EVQ_CODE);
  wire       do_text   = cmd_go & (cmd_op == sev_pkg::SEV_CMD_EVQ_TEXT);
  wire       do_all    = cmd_go & (cmd_op == sev_pkg::SEV_CMD_EVQ_ALL);
  wire       do_single = do_code | do_text;
  wire       all_on    = (rd_state_reg == sev_pkg::SEV_RD_ALL);

  // The all-events read streams one entry a cycle and holds off commands.
  assign cmd_ready = ~all_on;

  // ***********************************************************
  // Event sources
  // ***********************************************************
  wire       fire_ext   = ev_valid & ere_reg[ev_bit];
  wire [7:0] ext_set    = fire_ext ? (8'h01 << ev_bit) : 8'h00;
  wire       oq_lost    = msg_start & oq_full_reg;
  wire       oq_empty_rd = oq_read & ~oq_full_reg & ~oq_read_pending;
  wire       qye_evt    = oq_lost | oq_empty_rd;
  wire       opc_done   = opc_armed_reg & ~ops_pending;
  wire [2:0] int_raw    = {pon_pulse_reg, qye_evt, opc_done};
  wire [2:0] int_en     = {ere_reg[sev_pkg::SEV_BIT_PON],
                           ere_reg[sev_pkg::SEV_BIT_QYE],
                           ere_reg[sev_pkg::SEV_BIT_OPC]};
  wire [2:0] int_new    = int_raw & int_en;
  wire [7:0] int_set    = ({7'h00, int_new[2]} << sev_pkg::SEV_BIT_PON)
                        | ({7'h00, int_new[1]} << sev_pkg::SEV_BIT_QYE)
                        | ({7'h00, int_new[0]} << sev_pkg::SEV_BIT_OPC);

  // A new event in the clearing cycle survives the latch read.
  assign latch_next = (do_latch ? sev_pkg::SEV_ZERO8 : latch_reg)
                    | ext_set | int_set;

  assign opc_armed_next = opc_cmd | (opc_armed_reg & ops_pending);

  // Internal events wait here for a cycle with no outside event to push.
  wire [2:0] take = fire_ext       ? 3'h0 :
                    pend_reg[2]    ? 3'h4 :
                    pend_reg[1]    ? 3'h2 :
                    pend_reg[0]    ? 3'h1 : 3'h0;
  assign pend_next = (pend_reg & ~take) | int_new;

  wire        any_push  = fire_ext | (|pend_reg);
  wire [15:0] push_code = fire_ext    ? ev_code  :
                          pend_reg[2] ? PON_CODE :
                          pend_reg[1] ? QYE_CODE : OPC_CODE;

  // ***********************************************************
  // Status summary byte
  // ***********************************************************
  wire event_summary_bit = |(latch_reg & sem_reg);
  wire message_available = oq_full_reg;
  wire [7:0] sbr_raw = ({7'h00, event_summary_bit} << sev_pkg::SEV_SBR_ESB)
                     | ({7'h00, message_available} << sev_pkg::SEV_SBR_MAV);
  wire summary = |(sbr_raw & srm_reg);
  wire [7:0] sbr_query = sbr_raw
                       | ({7'h00, summary} << sev_pkg::SEV_SBR_SUM);
  wire [7:0] sbr_poll  = sbr_raw
                       | ({7'h00, rqs_reg} << sev_pkg::SEV_SBR_SUM);

  // A fresh summary edge wins over a poll in the same cycle.
  assign rqs_next = (summary & ~sum_d_reg)
                  | (rqs_reg & summary & ~do_poll);
  assign service_request = rqs_reg;

  // ***********************************************************
  // Output queue
  // ***********************************************************
  // A response put in the same cycle as a new message is the new one.
  assign oq_full_next = oq_put
                      | (oq_full_reg & ~oq_take & ~msg_start);

  // ***********************************************************
  // Enable masks and response mux
  // ***********************************************************
  assign ere_next = do_ere_wr ? cmd_data : ere_reg;
  assign sem_next = do_sem_wr ? cmd_data : sem_reg;
  assign srm_next = do_srm_wr ? (cmd_data & sev_pkg::SEV_SRM_USED)
                              : srm_reg;
  assign psc_next = do_psc_wr ? cmd_data[0] : psc_reg;

  assign resp_next = do_latch  ? latch_reg :
                     do_stb    ? sbr_query :
                     do_poll   ? sbr_poll  :
                     do_ere_rd ? ere_reg   :
                     do_sem_rd ? sem_reg   :
                     do_srm_rd ? srm_reg   :
                     do_psc_rd ? {7'h00, psc_reg} : sev_pkg::SEV_ZERO8;
  assign resp_valid_next = do_latch | do_stb | do_poll | do_ere_rd
                         | do_sem_rd | do_srm_rd | do_psc_rd;

  // ***********************************************************
  // Event queue pointers
  // ***********************************************************
  wire       have   = (avail_reg != 6'h00);
  wire       pop_en = (do_single | all_on) & have;
  wire [5:0] rd_adv = do_latch ? avail_reg :
                      pop_en   ? 6'h01 : 6'h00;
  wire       full_eff = ((count_reg - rd_adv) == sev_pkg::SEV_EVQ_DEPTH);
  wire       push_en  = any_push & ~full_eff;
  wire       over_en  = any_push & full_eff;
  wire [5:0] over_idx = (wr_reg == 6'h00)
                      ? (sev_pkg::SEV_EVQ_DEPTH - 6'h01)
                      : (wr_reg - 6'h01);

  assign rd_next    = sev_wrap(rd_reg, rd_adv);
  assign wr_next    = sev_wrap(wr_reg, {5'h00, push_en});
  assign count_next = count_reg - rd_adv + {5'h00, push_en};
  // Events queued after a latch read stay hidden until the next one.
  assign avail_next = do_latch ? (count_reg - avail_reg)
                               : (avail_reg - {5'h00, pop_en});

  assign rd_state_next = do_all                   ? sev_pkg::SEV_RD_ALL  :
                         (all_on & (avail_reg > 6'h01)) ? sev_pkg::SEV_RD_ALL
                                                  : sev_pkg::SEV_RD_IDLE;

  wire [15:0] head_code = have ? evq_mem[rd_reg] : sev_pkg::SEV_NONE_CODE;
  wire        evq_fire  = do_single | all_on;

  // ***********************************************************
  // Registers
  // ***********************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      latch_reg     <= sev_pkg::SEV_ZERO8;
      psc_reg       <= nv_psc_in;
      rqs_reg       <= 1'b0;
      sum_d_reg     <= 1'b0;
      oq_full_reg   <= 1'b0;
      opc_armed_reg <= 1'b0;
      pon_pulse_reg <= 1'b1;
      pend_reg      <= 3'h0;
      rd_state_reg  <= sev_pkg::SEV_RD_IDLE;
    end
    else
    begin
      latch_reg     <= latch_next;
      psc_reg       <= psc_next;
      rqs_reg       <= rqs_next;
      sum_d_reg     <= summary;
      oq_full_reg   <= oq_full_next;
      opc_armed_reg <= opc_armed_next;
      pon_pulse_reg <= 1'b0;
      pend_reg      <= pend_next;
      rd_state_reg  <= rd_state_next;
    end
  end

  // Masks come back from non-volatile store unless clear is selected.
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ere_reg <= nv_psc_in ? sev_pkg::SEV_ERE_CLR : nv_ere_in;
      sem_reg <= nv_psc_in ? sev_pkg::SEV_SEM_CLR : nv_sem_in;
      srm_reg <= nv_psc_in ? sev_pkg::SEV_SRM_CLR
                           : (nv_srm_in & sev_pkg::SEV_SRM_USED);
    end
    else
    begin
      ere_reg <= ere_next;
      sem_reg <= sem_next;
      srm_reg <= srm_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rd_reg    <= 6'h00;
      wr_reg    <= 6'h00;
      count_reg <= 6'h00;
      avail_reg <= 6'h00;
    end
    else
    begin
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      count_reg <= count_next;
      avail_reg <= avail_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push_en)
    begin
      evq_mem[wr_reg] <= push_code;
    end
    else if (over_en)
    begin
      evq_mem[over_idx] <= sev_pkg::SEV_OVF_CODE;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      resp_data  <= sev_pkg::SEV_ZERO8;
      resp_valid <= 1'b0;
      evq_code   <= sev_pkg::SEV_NONE_CODE;
      evq_valid  <= 1'b0;
      evq_text   <= 1'b0;
      evq_last   <= 1'b0;
    end
    else
    begin
      resp_data  <= resp_next;
      resp_valid <= resp_valid_next;
      evq_code   <= evq_fire ? head_code : sev_pkg::SEV_NONE_CODE;
      evq_valid  <= evq_fire;
      evq_text   <= do_text | do_all | all_on;
      evq_last   <= do_single | (all_on & (avail_reg <= 6'h01));
    end
  end

  assign nv_psc_out = psc_reg;
  assign nv_ere_out = ere_reg;
  assign nv_sem_out = sem_reg;
  assign nv_srm_out = srm_reg;

endmodule

// file: hw/sev_pkg.sv
// Constants and types shared by the status and event reporting unit.
package sev_pkg;

  // ***********************************************************
  // Register widths and event latch layout
  // ***********************************************************
  localparam int          SEV_REG_W    = 8;
  localparam int          SEV_CODE_W   = 16;
  localparam int          SEV_BIT_PON  = 7;
  localparam int          SEV_BIT_URQ  = 6;
  localparam int          SEV_BIT_CME  = 5;
  localparam int          SEV_BIT_EXE  = 4;
  localparam int          SEV_BIT_DDE  = 3;
  localparam int          SEV_BIT_QYE  = 2;
  localparam int          SEV_BIT_RQC  = 1;
  localparam int          SEV_BIT_OPC  = 0;

  // ***********************************************************
  // Status summary byte layout
  // ***********************************************************
  localparam int          SEV_SBR_SUM  = 6;
  localparam int          SEV_SBR_ESB  = 5;
  localparam int          SEV_SBR_MAV  = 4;
  localparam logic [7:0]  SEV_SRM_USED = 8'h30;

  // ***********************************************************
  // Power-on-clear mask values
  // ***********************************************************
  localparam logic [7:0]  SEV_ERE_CLR  = 8'hff;
  localparam logic [7:0]  SEV_SEM_CLR  = 8'h00;
  localparam logic [7:0]  SEV_SRM_CLR  = 8'h00;
  localparam logic [7:0]  SEV_ZERO8    = 8'h00;

  // ***********************************************************
  // Event queue
  // ***********************************************************
  localparam int          SEV_PTR_W    = 6;
  localparam logic [5:0]  SEV_EVQ_DEPTH = 6'h28;
  localparam logic [15:0] SEV_OVF_CODE = 16'h015e;
  localparam logic [15:0] SEV_NONE_CODE = 16'h0000;

  // ***********************************************************
  // Command codes and reader states
  // ***********************************************************
  typedef enum logic [3:0] {
    SEV_CMD_LATCH_RD = 4'h0,
    SEV_CMD_STB_QRY  = 4'h1,
    SEV_CMD_POLL     = 4'h2,
    SEV_CMD_ERE_WR   = 4'h3,
    SEV_CMD_ERE_RD   = 4'h4,
    SEV_CMD_SEM_WR   = 4'h5,
    SEV_CMD_SEM_RD   = 4'h6,
    SEV_CMD_SRM_WR   = 4'h7,
    SEV_CMD_SRM_RD   = 4'h8,
    SEV_CMD_PSC_WR   = 4'h9,
    SEV_CMD_PSC_RD   = 4'ha,
    SEV_CMD_EVQ_CODE = 4'hb,
    SEV_CMD_EVQ_TEXT = 4'hc,
    SEV_CMD_EVQ_ALL  = 4'hd
  } sev_cmd_e;

  typedef enum logic [0:0] {
    SEV_RD_IDLE = 1'b0,
    SEV_RD_ALL  = 1'b1
  } sev_rd_e;

endpackage

// file: test/sev_status_event_properties.sv
// Port-level checker for the status and event reporting unit.
`timescale 1ns/1ps
module sev_status_event_props (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       cmd_valid,
  input wire logic [3:0] cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic       cmd_ready,
  input wire logic [7:0] resp_data,
  input wire logic       resp_valid,
  input wire logic       evq_valid,
  input wire logic       evq_text,
  input wire logic       evq_last,
  input wire logic       service_request,
  input wire logic       nv_psc_in,
  input wire logic [7:0] nv_ere_out,
  input wire logic [7:0] nv_sem_out,
  input wire logic [7:0] nv_srm_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire take = cmd_valid && cmd_ready;
  wire is_rd = cmd_op inside {sev_pkg::SEV_CMD_LATCH_RD,
    sev_pkg::SEV_CMD_STB_QRY, sev_pkg::SEV_CMD_POLL,
    sev_pkg::SEV_CMD_ERE_RD, sev_pkg::SEV_CMD_SEM_RD,
    sev_pkg::SEV_CMD_SRM_RD, sev_pkg::SEV_CMD_PSC_RD};
  wire is_wr = cmd_op inside {sev_pkg::SEV_CMD_ERE_WR,
    sev_pkg::SEV_CMD_SEM_WR, sev_pkg::SEV_CMD_SRM_WR,
    sev_pkg::SEV_CMD_PSC_WR};
  wire is_poll = cmd_op == sev_pkg::SEV_CMD_POLL;
  wire is_stb = cmd_op == sev_pkg::SEV_CMD_STB_QRY;
  property p_reg_answer;
    take && is_rd |=> resp_valid && !evq_valid;
  endproperty
  a_reg_answer: assert property (p_reg_answer)
    else $error("register read gave no single answer");
  property p_wr_silent;
    take && is_wr |=> !resp_valid && !evq_valid;
  endproperty
  a_wr_silent: assert property (p_wr_silent)
    else $error("write produced an answer");
  property p_code_read;
    take && cmd_op == sev_pkg::SEV_CMD_EVQ_CODE
      |=> evq_valid && evq_last && !evq_text;
  endproperty
  a_code_read: assert property (p_code_read)
    else $error("code read gave wrong entry form");
  property p_text_read;
    take && cmd_op == sev_pkg::SEV_CMD_EVQ_TEXT |=> evq_valid && evq_text;
  endproperty
  a_text_read: assert property (p_text_read)
    else $error("text read lacks text flag");
  property p_stream_hold;
    evq_valid && !evq_last |-> !cmd_ready ##1 evq_valid;
  endproperty
  a_stream_hold: assert property (p_stream_hold)
    else $error("all-events stream broke off");
  property p_status_unused;
    take && (is_stb || is_poll) |=> (resp_data & 8'h8f) == 8'h00;
  endproperty
  a_status_unused: assert property (p_status_unused)
    else $error("unused status bits set");
  property p_poll_rqs;
    take && is_poll && service_request |=> resp_data[6];
  endproperty
  a_poll_rqs: assert property (p_poll_rqs)
    else $error("poll lost requested flag");
  property p_srm_write;
    take && cmd_op == sev_pkg::SEV_CMD_SRM_WR
      |=> nv_srm_out == ($past(cmd_data) & sev_pkg::SEV_SRM_USED);
  endproperty
  a_srm_write: assert property (p_srm_write)
    else $error("service mask write wrong");
  property p_ere_write;
    take && cmd_op == sev_pkg::SEV_CMD_ERE_WR |=> nv_ere_out == $past(cmd_data);
  endproperty
  a_ere_write: assert property (p_ere_write)
    else $error("record enable write wrong");
  property p_pon_clear;
    @(posedge clk) disable iff (1'b0)
    !rst_b && nv_psc_in |=> nv_ere_out == 8'hff && nv_sem_out == 8'h00
      && nv_srm_out == 8'h00;
  endproperty
  a_pon_clear: assert property (p_pon_clear)
    else $error("power-on-clear masks wrong");
  c_poll: cover property (take && is_poll && service_request);
  c_stream: cover property (evq_valid && !evq_last);
  c_srm: cover property (take && cmd_op == sev_pkg::SEV_CMD_SRM_WR);
endmodule

// file: test/sev_ctrl_model.sv
// Remote controller model: sends a message, then reads the response.
`timescale 1ns/1ps
module sev_ctrl_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic go,
  input  wire logic slow,
  output logic      msg_start,
  output logic      oq_read,
  output logic      oq_take
);
  logic [3:0] cnt_reg;
  logic       busy_reg;
  // A new go sends a message at once, even if the last response has not been read yet.
  always_ff @(posedge clk)
  begin
    msg_start <= go && rst_b;
    oq_read <= 1'b0;
    oq_take <= 1'b0;
    if (!rst_b)
    begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else if (go)
    begin
      busy_reg <= 1'b1;
      cnt_reg <= slow ? 4'h6 : 4'h1;
    end
    else if (busy_reg && cnt_reg == 4'h0)
    begin
      oq_read <= 1'b1;
      oq_take <= 1'b1;
      busy_reg <= 1'b0;
    end
    else if (busy_reg)
      cnt_reg <= cnt_reg - 4'h1;
  end
endmodule

// file: test/sev_status_event_tb.sv
// Self-checking testbench for the status and event reporting unit.
`timescale 1ns/1ps
module sev_status_event_tb;
  localparam logic [15:0] POWER_ON_FLAG = 16'h0001;
  logic        clk = 0, rst_b = 0, ev_valid = 0, opc_cmd = 0;
  logic        ops_pending = 0, oq_put = 0, oq_read_pending = 0;
  logic        cmd_valid = 0, nv_psc_in = 1, go = 0, slow = 0;
  logic [2:0]  ev_bit = 0;
  logic [15:0] ev_code = 0;
  logic [3:0]  cmd_op = 0;
  logic [7:0]  cmd_data = 0, nv_ere_in = 0, nv_sem_in = 0, nv_srm_in = 0;
  wire         msg_start, oq_read, oq_take, cmd_ready, resp_valid;
  wire         evq_valid, evq_text, evq_last, service_request, nv_psc_out;
  wire  [7:0]  resp_data, nv_ere_out, nv_sem_out, nv_srm_out;
  wire  [15:0] evq_code;
  int          errors = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  sev_status_event #(.PON_CODE(POWER_ON_FLAG)) dut (.clk(clk), .rst_b(rst_b),
    .ev_valid(ev_valid), .ev_bit(ev_bit), .ev_code(ev_code),
    .opc_cmd(opc_cmd), .ops_pending(ops_pending), .oq_put(oq_put),
    .oq_take(oq_take), .oq_read(oq_read), .oq_read_pending(oq_read_pending),
    .msg_start(msg_start), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ready(cmd_ready), .resp_data(resp_data),
    .resp_valid(resp_valid), .evq_code(evq_code), .evq_valid(evq_valid),
    .evq_text(evq_text), .evq_last(evq_last),
    .service_request(service_request), .nv_psc_in(nv_psc_in),
    .nv_ere_in(nv_ere_in), .nv_sem_in(nv_sem_in), .nv_srm_in(nv_srm_in),
    .nv_psc_out(nv_psc_out), .nv_ere_out(nv_ere_out),
    .nv_sem_out(nv_sem_out), .nv_srm_out(nv_srm_out));
  sev_ctrl_model u_ctrl (.clk(clk), .rst_b(rst_b), .go(go), .slow(slow),
    .msg_start(msg_start), .oq_read(oq_read), .oq_take(oq_take));
  task automatic close_out();
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [3:0] op, input logic [7:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_data <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] op, input logic [7:0] exp);
    cmd(op, 8'h00);
    chk({resp_valid, resp_data}, {1'b1, exp});
  endtask
  task automatic fetch(input logic [3:0] op, input logic [15:0] code,
                       input logic txt);
    cmd(op, 8'h00);
    chk({evq_valid, evq_text, evq_code}, {1'b1, txt, code});
  endtask
  task automatic ev(input logic [2:0] b, input logic [15:0] code);
    @(posedge clk);
    ev_valid <= 1'b1;
    ev_bit <= b;
    ev_code <= code;
    @(posedge clk);
    ev_valid <= 1'b0;
  endtask
  task automatic do_reset(input logic psc);
    @(posedge clk);
    rst_b <= 1'b0;
    nv_psc_in <= psc;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  task automatic query(input logic s);
    @(posedge clk);
    go <= 1'b1;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end
  initial
  begin
    do_reset(1'b1);
    rd(sev_pkg::SEV_CMD_ERE_RD, 8'hff);
    rd(sev_pkg::SEV_CMD_SEM_RD, 8'h00);
    rd(sev_pkg::SEV_CMD_SRM_RD, 8'h00);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h80);
    fetch(sev_pkg::SEV_CMD_EVQ_TEXT, POWER_ON_FLAG, 1'b1);
    fetch(sev_pkg::SEV_CMD_EVQ_CODE, 16'h0000, 1'b0);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h00);
    cmd(sev_pkg::SEV_CMD_ERE_WR, 8'h10);
    ev(3'd5, 16'h00be);
    ev(3'd4, 16'h00c8);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h10);
    cmd(sev_pkg::SEV_CMD_SRM_WR, 8'hff);
    rd(sev_pkg::SEV_CMD_SRM_RD, 8'h30);
    cmd(sev_pkg::SEV_CMD_SEM_WR, 8'h10);
    ev(3'd4, 16'h00d2);
    rd(sev_pkg::SEV_CMD_STB_QRY, 8'h60);
    chk(service_request, 1'b1);
    rd(sev_pkg::SEV_CMD_POLL, 8'h60);
    chk(service_request, 1'b0);
    rd(sev_pkg::SEV_CMD_STB_QRY, 8'h60);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h10);
    fetch(sev_pkg::SEV_CMD_EVQ_CODE, 16'h00d2, 1'b0);
    rd(sev_pkg::SEV_CMD_STB_QRY, 8'h00);
    cmd(sev_pkg::SEV_CMD_ERE_WR, 8'hff);
    @(posedge clk) oq_put <= 1'b1;
    @(posedge clk) oq_put <= 1'b0;
    rd(sev_pkg::SEV_CMD_STB_QRY, 8'h50);
    query(1'b0);
    rd(sev_pkg::SEV_CMD_STB_QRY, 8'h00);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h04);
    @(posedge clk) oq_read_pending <= 1'b1;
    query(1'b1);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h00);
    @(posedge clk) oq_read_pending <= 1'b0;
    ops_pending <= 1'b1;
    opc_cmd <= 1'b1;
    @(posedge clk) opc_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h00);
    @(posedge clk) ops_pending <= 1'b0;
    repeat (3) @(posedge clk);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h01);
    fetch(sev_pkg::SEV_CMD_EVQ_CODE, 16'h0003, 1'b0);
    for (int i = 0; i < 41; i++)
      ev(3'd3, 16'h0100 + i[15:0]);
    rd(sev_pkg::SEV_CMD_LATCH_RD, 8'h08);
    cmd(sev_pkg::SEV_CMD_EVQ_ALL, 8'h00);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk) #1;
      chk({evq_valid, evq_last, evq_code}, {1'b1, i == 39,
        i == 39 ? 16'h015e : 16'h0100 + i[15:0]});
    end
    cmd(sev_pkg::SEV_CMD_PSC_WR, 8'h00);
    chk(nv_psc_out, 1'b0);
    nv_ere_in <= 8'h5a;
    nv_sem_in <= 8'h3c;
    nv_srm_in <= 8'hff;
    do_reset(1'b0);
    rd(sev_pkg::SEV_CMD_ERE_RD, 8'h5a);
    rd(sev_pkg::SEV_CMD_SEM_RD, 8'h3c);
    rd(sev_pkg::SEV_CMD_SRM_RD, 8'h30);
    close_out();
  end
endmodule
bind sev_status_event sev_status_event_props u_props (.clk(clk),
  .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_data(cmd_data), .cmd_ready(cmd_ready), .resp_data(resp_data),
  .resp_valid(resp_valid), .evq_valid(evq_valid), .evq_text(evq_text),
  .evq_last(evq_last), .service_request(service_request),
  .nv_psc_in(nv_psc_in), .nv_ere_out(nv_ere_out),
  .nv_sem_out(nv_sem_out), .nv_srm_out(nv_srm_out));
